// [jtag_ctrl_model.sv]
// behavioural boundary-scan controller driving the test port
`timescale 1ns/1ps
module jtag_ctrl_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    import sram_tap_pkg::*;
    // test clock stands low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one test clock, tdo taken just before the rise
    task automatic clk(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #7.5;
        q = tdo;
        tck = 1'b1;
        #7.5;
        tck = 1'b0;
    endtask
    // state moves; tdi toggles so a stale level is never taken for data
    task automatic walk(input logic [15:0] p, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            clk(p[i], ~tdi, q);
        end
    endtask
    // shift n bits lsb first, tms high on the last
    task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            clk(i == n - 1, din[i], dout[i]);
        end
    endtask
    // from idle into shift-ir, stop in exit1-ir; reserved codes are never sent
    task automatic ir_shift(input logic [2:0] code, output logic [2:0] cap);
        logic [127:0] q;
        if (code inside {INS_RSVD_A, INS_RSVD_B, INS_RSVD_C}) code = INS_BYPASS;
        walk(16'h0003, 4);
        shift(3, {125'h0, code}, q);
        cap = q[2:0];
    endtask
    // full instruction load back to idle
    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        ir_shift(code, cap);
        walk(16'h0001, 2);
    endtask
    // capture, shift and update a data register from idle
    task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
        walk(16'h0001, 3);
        shift(n, din, dout);
        walk(16'h0001, 2);
    endtask
    // nine tms ones into test-logic-reset, then idle
    task automatic tlr();
        walk(16'h01FF, 10);
    endtask
endmodule

// [level_sync.sv]
// three flip-flop level synchroniser, output changes once stages two and three agree
`timescale 1ns/1ps
module level_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic d,
    output logic q
);
    logic s1;
    logic s2;
    logic s3;

    // capture chain, only s2 reads s1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else if (en) begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // accept a change only when the later stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (en && (s2 == s3)) begin
            q <= s3;
        end
    end
endmodule

// [sram_tap.sv]
// boundary-scan test access port of the pipelined sram with apb configuration
`timescale 1ns/1ps
module sram_tap #(
    parameter logic [3:0] REV_CODE = 4'h1,        // arbitrary value
    parameter logic [4:0] DEPTH_CODE_WIDE = 5'h05,    // arbitrary value
    parameter logic [4:0] DEPTH_CODE_NARROW = 5'h06,  // arbitrary value
    parameter logic [4:0] WIDTH_CODE_WIDE = 5'h09,    // arbitrary value
    parameter logic [4:0] WIDTH_CODE_NARROW = 5'h0A,  // arbitrary value
    parameter logic [5:0] DEV_CODE = 6'h00,           // arbitrary value
    parameter logic [10:0] MFR_CODE = 11'h2A5         // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [sram_tap_pkg::BSR_WIDE-1:0] io_ring,
    output logic mem_outputs_hiz
);
    import sram_tap_pkg::*;

    logic wide_org;
    logic wide_tck;
    logic narrow_tck;
    logic hiz_tck;
    logic hiz_pclk;
    tap_state_t tap_state;
    tap_state_t next_tap_state;
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] active_ir;
    logic [ID_W-1:0] id_shift;
    logic [ID_W-1:0] id_value;
    logic [BSR_WIDE-1:0] bsr;
    logic [BSR_WIDE-1:0] next_bsr;
    logic bypass_bit;
    logic sel_bsr;
    logic sel_id;
    logic scan_out;
    logic apb_access;
    logic hit_ctrl;
    logic hit_status;

    // ---------------- apb side (pclk) ----------------

    // address decode for the access phase
    assign apb_access = psel && penable && !pready;
    assign hit_ctrl = (paddr == OFF_CTRL);
    assign hit_status = (paddr == OFF_STATUS);

    // ready pulses one cycle after the access phase starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (clk_en) begin
            pready <= apb_access;
        end
    end

    // unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pslverr <= apb_access && !hit_ctrl && !hit_status;
        end
    end

    // organisation select written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_org <= CTRL_WIDE_RST;
        end else if (clk_en && apb_access && pwrite && hit_ctrl) begin
            wide_org <= pwdata[CTRL_WIDE];
        end
    end

    // read data, zero outside the mapped bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            prdata <= 32'h0000_0000;
            if (apb_access && !pwrite) begin
                if (hit_ctrl) begin
                    prdata[CTRL_WIDE] <= wide_org;
                end else if (hit_status) begin
                    prdata[STAT_HIZ] <= hiz_pclk;
                    prdata[STAT_WIDE] <= wide_org;
                end
            end
        end
    end

    // float request from the test clock side
    level_sync u_hiz_sync (
        .clk(pclk),
        .rst_n(presetn),
        .en(clk_en),
        .d(hiz_tck),
        .q(hiz_pclk)
    );

    // memory output enable override
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_outputs_hiz <= 1'b0;
        end else if (clk_en) begin
            mem_outputs_hiz <= hiz_pclk;
        end
    end

    // ---------------- test clock side (tck) ----------------

    // organisation select carried into the test clock domain, inverted so that the
    // cleared synchroniser already means wide and the first capture after reset is right
    level_sync u_wide_sync (
        .clk(tck),
        .rst_n(presetn),
        .en(1'b1),
        .d(!wide_org),
        .q(narrow_tck)
    );
    assign wide_tck = !narrow_tck;

    // controller next state from tms
    always_comb begin
        next_tap_state = tap_state;
        case (tap_state)
            TLR: next_tap_state = tms ? TLR : RTI;
            RTI: next_tap_state = tms ? SEL_DR : RTI;
            SEL_DR: next_tap_state = tms ? SEL_IR : CAP_DR;
            CAP_DR: next_tap_state = tms ? EX1_DR : SH_DR;
            SH_DR: next_tap_state = tms ? EX1_DR : SH_DR;
            EX1_DR: next_tap_state = tms ? UPD_DR : PAU_DR;
            PAU_DR: next_tap_state = tms ? EX2_DR : PAU_DR;
            EX2_DR: next_tap_state = tms ? UPD_DR : SH_DR;
            UPD_DR: next_tap_state = tms ? SEL_DR : RTI;
            SEL_IR: next_tap_state = tms ? TLR : CAP_IR;
            CAP_IR: next_tap_state = tms ? EX1_IR : SH_IR;
            SH_IR: next_tap_state = tms ? EX1_IR : SH_IR;
            EX1_IR: next_tap_state = tms ? UPD_IR : PAU_IR;
            PAU_IR: next_tap_state = tms ? EX2_IR : PAU_IR;
            EX2_IR: next_tap_state = tms ? UPD_IR : SH_IR;
            UPD_IR: next_tap_state = tms ? SEL_DR : RTI;
            default: next_tap_state = TLR;
        endcase
    end

    // controller state on rising test clock
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            tap_state <= TLR;
        end else begin
            tap_state <= next_tap_state;
        end
    end

    // instruction shift stage
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            ir_shift <= IR_CAPTURE;
        end else if (tap_state == CAP_IR) begin
            ir_shift <= IR_CAPTURE;
        end else if (tap_state == SH_IR) begin
            ir_shift <= {tdi, ir_shift[IR_W-1:1]};
        end
    end

    // active instruction, reloaded with identification on reset
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            active_ir <= INS_IDCODE;
        end else if (tap_state == TLR) begin
            active_ir <= INS_IDCODE;
        end else if (tap_state == UPD_IR) begin
            active_ir <= ir_shift;
        end
    end

    // data register selection; unused codes fall back to bypass
    always_comb begin
        sel_bsr = 1'b0;
        sel_id = 1'b0;
        case (active_ir)
            INS_EXTEST: sel_bsr = 1'b1;
            INS_SAMPLE_Z: sel_bsr = 1'b1;
            INS_SAMPLE: sel_bsr = 1'b1;
            INS_IDCODE: sel_id = 1'b1;
            INS_BYPASS: sel_id = 1'b0;
            INS_RSVD_A, INS_RSVD_B, INS_RSVD_C: sel_id = 1'b0;
            default: sel_id = 1'b0;
        endcase
    end

    // memory outputs float under the two capture-and-float codes; follows the
    // active instruction at the same edge, as the test clock may stop right after
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            hiz_tck <= 1'b0;
        end else if (tap_state == TLR) begin
            hiz_tck <= 1'b0;
        end else if (tap_state == UPD_IR) begin
            hiz_tck <= (ir_shift == INS_EXTEST) || (ir_shift == INS_SAMPLE_Z);
        end
    end

    // identification word assembled per organisation
    always_comb begin
        id_value = '0;
        id_value[ID_REV_HI:ID_REV_LO] = REV_CODE;
        id_value[ID_DEPTH_HI:ID_DEPTH_LO] = wide_tck ? DEPTH_CODE_WIDE : DEPTH_CODE_NARROW;
        id_value[ID_WIDTH_HI:ID_WIDTH_LO] = wide_tck ? WIDTH_CODE_WIDE : WIDTH_CODE_NARROW;
        id_value[ID_DEV_HI:ID_DEV_LO] = DEV_CODE;
        id_value[ID_MFR_HI:ID_MFR_LO] = MFR_CODE;
        id_value[ID_LSB] = ID_LSB_VAL;
    end

    // identification register capture and shift
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            id_shift <= '0;
        end else if (sel_id && tap_state == CAP_DR) begin
            id_shift <= id_value;
        end else if (sel_id && tap_state == SH_DR) begin
            id_shift <= {tdi, id_shift[ID_W-1:1]};
        end
    end

    // boundary shift: msb takes data in (bit BSR_NARROW-1 in narrow organisation), lsb feeds data out
    always_comb begin
        next_bsr = bsr;
        for (int i = 0; i < BSR_WIDE - 1; i++) begin
            next_bsr[i] = bsr[i+1];
        end
        next_bsr[BSR_WIDE-1] = tdi;
        if (!wide_tck) begin
            next_bsr[BSR_NARROW-1] = tdi;
        end
    end

    // boundary register capture of the I/O ring; update does nothing
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            bsr <= '0;
        end else if (sel_bsr && tap_state == CAP_DR) begin
            bsr <= io_ring;
        end else if (sel_bsr && tap_state == SH_DR) begin
            bsr <= next_bsr;
        end
    end

    // single bypass stage, captures zero
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            bypass_bit <= 1'b0;
        end else if (!sel_bsr && !sel_id && tap_state == CAP_DR) begin
            bypass_bit <= 1'b0;
        end else if (!sel_bsr && !sel_id && tap_state == SH_DR) begin
            bypass_bit <= tdi;
        end
    end

    // serial output selection
    always_comb begin
        if (tap_state == SH_IR) begin
            scan_out = ir_shift[0];
        end else if (sel_bsr) begin
            scan_out = bsr[0];
        end else if (sel_id) begin
            scan_out = id_shift[0];
        end else begin
            scan_out = bypass_bit;
        end
    end

    // data out changes on the falling test clock edge, driven only while shifting
    always_ff @(negedge tck or negedge presetn) begin
        if (!presetn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo <= scan_out;
            tdo_oe <= (tap_state == SH_IR) || (tap_state == SH_DR);
        end
    end
endmodule

// [sram_tap_assertions.sv]
// concurrent checks on the ports of the sram test access port
`timescale 1ns/1ps
module sram_tap_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo_oe,
    input wire logic mem_outputs_hiz
);
    import sram_tap_pkg::*;
    // access phase accepted at this edge
    wire logic take = psel && penable && !pready && clk_en;
    wire logic mapped = paddr == OFF_CTRL || paddr == OFF_STATUS;
    // bus answer timing and content, scan port state
    a_one_wait: assert property (@(posedge pclk) disable iff (!presetn) take |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready && clk_en |=> !pready) else $error("pready held");
    a_err_needs_ready: assert property (@(posedge pclk) disable iff (!presetn) pslverr |-> pready)
        else $error("pslverr alone");
    a_idle_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0) else $error("prdata not zero");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        take && !mapped |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
        take && mapped |=> !pslverr) else $error("mapped refused");
    a_tlr_no_float: assert property (@(posedge tck) disable iff (!presetn)
        tms [*5] ##1 tms [*4] |-> !mem_outputs_hiz) else $error("float after reset state");
    a_oe_off_shift: assert property (@(posedge tck) disable iff (!presetn)
        tms [*2] |-> !tdo_oe) else $error("tdo driven outside shift");
    // main scenarios reached
    cover property (@(posedge pclk) pslverr);
    cover property (@(posedge pclk) $rose(mem_outputs_hiz));
    cover property (@(posedge tck) tdo_oe);
endmodule

bind sram_tap sram_tap_assertions sram_tap_assertions_inst (.pclk, .presetn, .clk_en, .psel,
    .penable, .paddr, .prdata, .pready, .pslverr, .tck, .tms, .tdo_oe, .mem_outputs_hiz);

// [sram_tap_pkg.sv]
// constants, encodings and types shared by the sram test access port
package sram_tap_pkg;
    // instruction register
    localparam int IR_W = 3;
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] INS_RSVD_A = 3'h3;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_RSVD_B = 3'h5;
    localparam logic [IR_W-1:0] INS_RSVD_C = 3'h6;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    // boundary scan lengths
    localparam int BSR_WIDE = 70;
    localparam int BSR_NARROW = 51;
    // identification register layout
    localparam int ID_W = 32;
    localparam int ID_REV_HI = 31;
    localparam int ID_REV_LO = 28;
    localparam int ID_DEPTH_HI = 27;
    localparam int ID_DEPTH_LO = 23;
    localparam int ID_WIDTH_HI = 22;
    localparam int ID_WIDTH_LO = 18;
    localparam int ID_DEV_HI = 17;
    localparam int ID_DEV_LO = 12;
    localparam int ID_MFR_HI = 11;
    localparam int ID_MFR_LO = 1;
    localparam int ID_LSB = 0;
    localparam logic ID_LSB_VAL = 1'b1;
    // apb register map
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam int CTRL_WIDE = 0;
    localparam int STAT_HIZ = 0;
    localparam int STAT_WIDE = 1;
    localparam logic CTRL_WIDE_RST = 1'b1;
    // tap controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;
endpackage

// [sram_tap_tb_top.sv]
// self-checking bench for the sram test access port
`timescale 1ns/1ps
module sram_tap_tb_top;
    import sram_tap_pkg::*;
    // identity fields, all values arbitrary
    localparam logic [3:0] REV = 4'h3;
    localparam logic [4:0] DW = 5'h11, DN = 5'h12, WW = 5'h13, WN = 5'h14; // arbitrary
    localparam logic [5:0] DEV = 6'h2A; // arbitrary
    localparam logic [10:0] MFR = 11'h155; // arbitrary
    localparam logic [31:0] ID_WIDE = {REV, DW, WW, DEV, MFR, 1'b1};
    localparam logic [31:0] ID_NARROW = {REV, DN, WN, DEV, MFR, 1'b1};
    localparam logic [69:0] IO = 70'h25_A5A5_C3C3_0F0F_9669;
    localparam logic [127:0] DIN = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, tck, tms, tdi, tdo, tdo_oe, hiz, wide = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [69:0] io_ring = IO;
    int errors = 0, comparisons = 0;
    sram_tap #(.REV_CODE(REV), .DEPTH_CODE_WIDE(DW), .DEPTH_CODE_NARROW(DN),
        .WIDTH_CODE_WIDE(WW), .WIDTH_CODE_NARROW(WN), .DEV_CODE(DEV), .MFR_CODE(MFR))
        sram_tap_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tck, .tms, .tdi, .tdo, .tdo_oe, .io_ring,
        .mem_outputs_hiz(hiz));
    jtag_ctrl_model jtag_ctrl_model_inst (.tck, .tms, .tdi, .tdo);
    // bus clock
    initial begin
        forever #4 pclk = ~pclk;
    end
    // count a comparison and report a difference
    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // load an instruction, check floating outputs, status and the selected scan path
    task automatic scan(input logic [2:0] code, input int len, input logic [127:0] cap, input int n);
        logic [2:0] c;
        logic [127:0] q;
        logic [31:0] r;
        logic e;
        logic hz;
        hz = code == INS_EXTEST || code == INS_SAMPLE_Z;
        jtag_ctrl_model_inst.load_ir(code, c);
        check("ir capture", IR_CAPTURE, c);
        repeat (8) @(posedge pclk);
        check("outputs floated", hz, hiz);
        apb(1'b0, OFF_STATUS, 32'h0, r, e);
        check("status", {wide, hz}, {e, r});
        jtag_ctrl_model_inst.scan_dr(n, DIN, q);
        check("scan path", ((DIN << len) | cap) & ((128'h1 << n) - 1), q);
    endtask
    // reset values, read-only status, unmapped places, stalled answer
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, OFF_CTRL, 32'h0, r, e);
        check("ctrl reset", 33'h1, {e, r});
        apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF, r, e);
        clk_en <= 1'b0;
        fork
            apb(1'b0, OFF_STATUS, 32'h0, r, e);
            begin
                repeat (4) @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        check("status read only", 33'h2, {e, r});
        apb(1'b0, 12'h008, 32'h0, r, e);
        check("unmapped read", 33'h1_0000_0000, {e, r});
        apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, r, e);
        check("unmapped write", 1'b1, e);
        $display("test regs done");
    endtask
    // identification after reset and after test-logic-reset, update-only loading
    task automatic t_reset();
        logic [127:0] q;
        logic [2:0] c;
        jtag_ctrl_model_inst.walk(16'h0000, 1);
        jtag_ctrl_model_inst.scan_dr(32, DIN, q);
        check("id after reset", ID_WIDE, q);
        jtag_ctrl_model_inst.ir_shift(INS_EXTEST, c);
        repeat (10) @(posedge pclk);
        check("float before update", 1'b0, hiz);
        jtag_ctrl_model_inst.walk(16'h0001, 2);
        repeat (8) @(posedge pclk);
        check("float after update", 1'b1, hiz);
        jtag_ctrl_model_inst.tlr();
        check("float after reset state", 1'b0, hiz);
        jtag_ctrl_model_inst.scan_dr(32, DIN, q);
        check("id after reset state", ID_WIDE, q);
        $display("test reset done");
    endtask
    // every defined instruction in wide organisation, then identification and sample in narrow
    task automatic t_orgs();
        logic [127:0] q;
        logic [31:0] r;
        logic e;
        scan(INS_EXTEST, 70, IO, 72);
        scan(INS_SAMPLE_Z, 70, IO, 72);
        scan(INS_SAMPLE, 70, IO, 72);
        scan(INS_BYPASS, 1, 0, 72);
        scan(INS_IDCODE, 32, ID_WIDE, 72);
        apb(1'b1, OFF_CTRL, 32'h0, r, e);
        wide = 1'b0;
        jtag_ctrl_model_inst.tlr();
        jtag_ctrl_model_inst.scan_dr(32, DIN, q);
        check("narrow id", ID_NARROW, q);
        scan(INS_SAMPLE, 51, IO[50:0], 60);
        apb(1'b1, OFF_CTRL, 32'h1, r, e);
        wide = 1'b1;
        $display("test organisations done");
    endtask
    // counts and verdict
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        #200us;
        errors++;
        $display("MISMATCH watchdog expected done seen hang");
        final_report();
    end
    // reset, scenarios, verdict
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_reset();
        t_orgs();
        final_report();
    end
endmodule
